// ### cshg_pkg.sv
// constants and types for the chopper sample-and-hold timing block
package cshg_pkg;
  // phase-locked clock runs at this multiple of the slot frequency
  localparam int unsigned CSHG_PLL_MULT = 10;
  // middle ticks of a slot half-period during which a gate may open
  localparam int unsigned CSHG_GATE_FIRST = 1;
  localparam int unsigned CSHG_GATE_LEN = 3;
  localparam int unsigned CSHG_CNT_W = 8;
  // synthetic detector waveform: low in each slot-low half and for the first ticks of each slot-high half, then high
  localparam int unsigned CSHG_TEST_EDGE = 2;
  localparam logic [3:0] CSHG_GATES_OFF = 4'h0;
  localparam logic [1:0] CSHG_GATE_SIG_WIN = 2'h0;
  localparam logic [1:0] CSHG_GATE_SIG_BASE = 2'h1;
  localparam logic [1:0] CSHG_GATE_CMP_WIN = 2'h2;
  localparam logic [1:0] CSHG_GATE_CMP_BASE = 2'h3;

  typedef enum logic [1:0] {
    CSHG_ST_RUN,
    CSHG_ST_DARK,
    CSHG_ST_ETEST
  } cshg_mode_t;
endpackage : cshg_pkg

// ### cshg_sync.sv
// two-stage synchroniser with edge outputs taken after the second stage
`timescale 1ns/1ps
`default_nettype none
module cshg_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule : cshg_sync
`default_nettype wire

// ### cshg_timing.sv
// sample-and-hold gate timing, sensor indicators and test switches
// Notes on behaviour
// - one gate from half-turn and slot level
// - four gate outputs from two sensors only
// - timed by clock at ten times slot
// - gates open only mid-pulse, closed at edges
// - phase LED follows half-turn sensor
// - slot LED follows slot sensor
// - dark calibration opens detector input switch
// - electrical test injects known synthetic waveform
`timescale 1ns/1ps
`default_nettype none
module cshg_timing
  import cshg_pkg::*;
#(
  parameter int unsigned GATE_FIRST = CSHG_GATE_FIRST,
  parameter int unsigned GATE_LEN = CSHG_GATE_LEN
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic phase_sense_i,
  input wire logic slot_sense_i,
  input wire logic dark_cal_i,
  input wire logic elec_test_i,
  output logic sig_win_gate_o,
  output logic sig_base_gate_o,
  output logic cmp_win_gate_o,
  output logic cmp_base_gate_o,
  output logic phase_indicator_led_o,
  output logic slot_indicator_led_o,
  output logic det_switch_closed_o,
  output logic test_inject_o,
  output logic test_wave_o
);
  logic phase_lvl;
  logic slot_lvl;
  logic slot_rise;
  logic slot_fall;
  logic slot_edge;
  logic [CSHG_CNT_W-1:0] tick_r;
  logic [3:0] gates_r;
  logic [3:0] gates_nxt;
  logic win_open;
  logic led_phase_r;
  logic led_slot_r;
  logic dark_r;
  logic inject_r;
  logic wave_r;
  cshg_mode_t mode_r;
  cshg_mode_t mode_nxt;

  // the pll output is clk_i itself; inputs are resynchronised to it
  cshg_sync u_phase_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(phase_sense_i),
    .level_o(phase_lvl),
    .rise_o(),
    .fall_o()
  );

  cshg_sync u_slot_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(slot_sense_i),
    .level_o(slot_lvl),
    .rise_o(slot_rise),
    .fall_o(slot_fall)
  );

  function automatic logic in_window(input logic [CSHG_CNT_W-1:0] t);
    in_window = (t >= CSHG_CNT_W'(GATE_FIRST)) && (t < CSHG_CNT_W'(GATE_FIRST + GATE_LEN));
  endfunction : in_window

  assign slot_edge = slot_rise | slot_fall;

  // ticks restart at each slot edge; with ten ticks per period each half holds five
  // reset parks the count past the window: no gate before the first slot edge is seen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_r <= '1;
    end else if (slot_edge) begin
      tick_r <= '0;
    end else if (tick_r != '1) begin
      tick_r <= tick_r + 1'b1;
    end
  end

  // edge ticks are excluded so a gate never spans a detector transition
  assign win_open = in_window(tick_r) && !slot_edge;

  always_comb begin
    gates_nxt = CSHG_GATES_OFF;
    if (win_open) begin
      unique case ({phase_lvl, slot_lvl})
        2'h3: gates_nxt[CSHG_GATE_SIG_WIN] = 1'b1;
        2'h2: gates_nxt[CSHG_GATE_SIG_BASE] = 1'b1;
        2'h1: gates_nxt[CSHG_GATE_CMP_WIN] = 1'b1;
        2'h0: gates_nxt[CSHG_GATE_CMP_BASE] = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gates_r <= CSHG_GATES_OFF;
    end else begin
      gates_r <= gates_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_phase_r <= 1'b0;
    end else begin
      led_phase_r <= phase_lvl;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_slot_r <= 1'b0;
    end else begin
      led_slot_r <= slot_lvl;
    end
  end

  // electrical test wins over dark calibration since it needs the switch open too
  always_comb begin
    if (elec_test_i) begin
      mode_nxt = CSHG_ST_ETEST;
    end else if (dark_cal_i) begin
      mode_nxt = CSHG_ST_DARK;
    end else begin
      mode_nxt = CSHG_ST_RUN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= CSHG_ST_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dark_r <= 1'b0;
    end else begin
      dark_r <= (mode_r != CSHG_ST_RUN);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inject_r <= 1'b0;
    end else begin
      inject_r <= (mode_r == CSHG_ST_ETEST);
    end
  end

  // synthetic pulse: rises a few ticks into each slot-high half, mimicking a real edge;
  // the edge-flag cycle still carries the old count, so it is masked to avoid a one-tick spike
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave_r <= 1'b0;
    end else if (mode_r == CSHG_ST_ETEST) begin
      wave_r <= slot_lvl && !slot_edge && (tick_r >= CSHG_CNT_W'(CSHG_TEST_EDGE));
    end else begin
      wave_r <= 1'b0;
    end
  end

  assign sig_win_gate_o = gates_r[CSHG_GATE_SIG_WIN];
  assign sig_base_gate_o = gates_r[CSHG_GATE_SIG_BASE];
  assign cmp_win_gate_o = gates_r[CSHG_GATE_CMP_WIN];
  assign cmp_base_gate_o = gates_r[CSHG_GATE_CMP_BASE];
  assign phase_indicator_led_o = led_phase_r;
  assign slot_indicator_led_o = led_slot_r;
  assign det_switch_closed_o = ~dark_r;
  assign test_inject_o = inject_r;
  assign test_wave_o = wave_r;
endmodule : cshg_timing
`default_nettype wire

// ### cshg_sva.sv
// port assertions for the gate timing block
`timescale 1ns/1ps
`default_nettype none
module cshg_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic phase_sense_i,
  input wire logic slot_sense_i,
  input wire logic dark_cal_i,
  input wire logic elec_test_i,
  input wire logic sig_win_gate_o,
  input wire logic sig_base_gate_o,
  input wire logic cmp_win_gate_o,
  input wire logic cmp_base_gate_o,
  input wire logic phase_indicator_led_o,
  input wire logic slot_indicator_led_o,
  input wire logic det_switch_closed_o,
  input wire logic test_inject_o,
  input wire logic test_wave_o
);
  wire [3:0] g = {sig_win_gate_o, sig_base_gate_o, cmp_win_gate_o, cmp_base_gate_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence open_s; (|g)[*3] ##1 !(|g); endsequence
  sequence shut_open_s; !(|g) ##1 (|g); endsequence
  one_gate_a: assert property ($onehot0(g)) else $error("gates overlap");
  gate_pick_a: assert property (|g |-> g == 4'h1 << {$past(phase_sense_i, 4), $past(slot_sense_i, 4)})
    else $error("wrong gate");
  gate_run_a: assert property ($rose(|g) |-> open_s) else $error("gate length");
  edge_gap_a: assert property ($changed(slot_sense_i) |-> ##4 shut_open_s) else $error("gate at edge");
  phase_led_a: assert property (phase_indicator_led_o == $past(phase_sense_i, 3)) else $error("phase led");
  slot_led_a: assert property (slot_indicator_led_o == $past(slot_sense_i, 3)) else $error("slot led");
  dark_sw_a: assert property (det_switch_closed_o == !($past(dark_cal_i, 2) || $past(elec_test_i, 2)))
    else $error("switch");
  inject_a: assert property (test_inject_o == $past(elec_test_i, 2)) else $error("inject");
  test_wave_a: assert property (test_wave_o |-> test_inject_o && $past(slot_sense_i, 3))
    else $error("test wave");
endmodule : cshg_sva
bind cshg_timing cshg_sva cshg_sva_inst (.*);
`default_nettype wire

// ### cshg_wheel.sv
// wheel sensor model
`timescale 1ns/1ps
`default_nettype none
module cshg_wheel (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [3:0] half_i,
  output logic phase_o,
  output logic slot_o
);
  int t = 0;
  int n = 0;
  initial {phase_o, slot_o} = 2'h0;
  // levels stand while stopped
  always @(negedge clk_i) begin
    if (run_i) begin
      t = t + 1;
      if (t >= half_i) begin
        t = 0;
        slot_o = !slot_o;
        n = n + slot_o;
        if (n == 3) begin
          n = 0;
          phase_o = !phase_o;
        end
      end
    end
  end
endmodule : cshg_wheel
`default_nettype wire

// ### cshg_tb.sv
// bench for the gate timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0, rst_n_i = 1'b0, dark_cal_i = 1'b0, elec_test_i = 1'b0, run = 1'b0;
  logic phase_sense_i, slot_sense_i, sig_win_gate_o, sig_base_gate_o, cmp_win_gate_o, cmp_base_gate_o;
  logic phase_indicator_led_o, slot_indicator_led_o, det_switch_closed_o, test_inject_o, test_wave_o;
  logic [11:0] hs = 12'h000, hp = 12'h000;
  logic [1:0] hd = 2'h0, he = 2'h0;
  logic [3:0] half = 4'h5;
  int errors = 0, samples_checked = 0;
  integer seed = 32'h10FEC8DB;
  always #2.5 clk_i = !clk_i;
  cshg_wheel cshg_wheel_inst (.clk_i, .run_i(run), .half_i(half), .phase_o(phase_sense_i), .slot_o(slot_sense_i));
  cshg_timing cshg_timing_inst (.*);
  function automatic logic [3:0] expect_gates();
    logic [3:0] g = 4'h0;
    // an edge sampled m cycles back shows its gate while m - 3 lies in the tick window
    for (int m = 10; m > 3; m--)
      if (hs[m] != hs[m+1])
        g = (m < 3 + cshg_pkg::CSHG_GATE_FIRST + cshg_pkg::CSHG_GATE_LEN) ? 4'h1 << {hp[m], hs[m]} : 4'h0;
    return g;
  endfunction : expect_gates
  task automatic tally(string what, logic [3:0] want, logic [3:0] got);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask : tally
  task automatic check_gates(logic [3:0] want);
    tally("gates", want, {sig_win_gate_o, sig_base_gate_o, cmp_win_gate_o, cmp_base_gate_o});
  endtask : check_gates
  task automatic check_leds(logic [1:0] want);
    tally("leds", 4'(want), 4'({phase_indicator_led_o, slot_indicator_led_o}));
  endtask : check_leds
  task automatic check_test(logic [2:0] want);
    tally("test", 4'(want), 4'({det_switch_closed_o, test_inject_o, test_wave_o}));
  endtask : check_test
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    hs <= {hs[10:0], slot_sense_i};
    hp <= {hp[10:0], phase_sense_i};
    hd <= {hd[0], dark_cal_i};
    he <= {he[0], elec_test_i};
  end
  // test wave needs the slot level held over the edge flag and the first ticks of the half
  always @(negedge clk_i) begin
    if (rst_n_i) begin
      check_gates(expect_gates());
      check_leds({hp[2], hs[2]});
      check_test({!(hd[1] || he[1]), he[1], he[1] & (&hs[5:2])});
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    run = 1'b1;
    repeat (30) begin
      repeat (80) @(negedge clk_i);
      half = 4'h5 + 4'($random(seed) & 3);
      {dark_cal_i, elec_test_i} = 2'($random(seed));
    end
    run = 1'b0;
    repeat (60) @(negedge clk_i);
    finish_test();
  end
  initial begin
    #20000;
    errors++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
